// >>> logic/alu_decode_pkg.sv
// Shared constants and carriers for the byte ALU, branch and bit-clear decoder
`default_nettype none
package alu_decode_pkg;
    localparam int   PC_W          = 21;
    localparam int   ADDR_W        = 12;
    localparam logic [5:0] OPC_ADDC_FILE = 6'h08;  // 0010 00da
    localparam logic [5:0] OPC_AND_FILE  = 6'h05;  // 0001 01da
    localparam logic [7:0] OPC_AND_IMM   = 8'h0B;  // 0000 1011
    localparam logic [7:0] OPC_BR_CARRY  = 8'hE2;  // 1110 0010
    localparam logic [3:0] OPC_BIT_CLR   = 4'h9;   // 1001 bbba
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ZERO_BANK     = 4'h0;
    localparam int   DEST_BIT      = 9;
    localparam int   BANK_BIT      = 8;
    localparam logic [PC_W-1:0] WORD_STEP = 21'h000002;

    typedef struct packed {
        logic negative;
        logic signedWrap;
        logic zero;
        logic halfCarry;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic              wrEn;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } mem_write_t;
endpackage
`default_nettype wire

// >>> logic/file_addr_resolve.sv
// Data memory address resolution for byte and bit file instructions
`default_nettype none
module file_addr_resolve (
    input  wire logic        [7:0]                         fileAddr,
    input  wire logic                                      bankSel,
    input  wire logic        [3:0]                         bankPointer,
    input  wire logic                                      extendedEn,
    input  wire logic        [7:0]                         indexBase,
    output logic             [alu_decode_pkg::ADDR_W-1:0]  memAddr
);
    always_comb begin
        if (bankSel) begin
            memAddr = {bankPointer, fileAddr}; // RL4
        end else if (extendedEn && (fileAddr <= alu_decode_pkg::INDEXED_LIMIT)) begin
            // Offset from index base wraps within the bank zero page
            memAddr = {alu_decode_pkg::ZERO_BANK, 8'(indexBase + fileAddr)}; // RL5
        end else if (fileAddr < alu_decode_pkg::ACCESS_SPLIT) begin
            memAddr = {alu_decode_pkg::ZERO_BANK, fileAddr}; // RL4
        end else begin
            memAddr = {alu_decode_pkg::ACCESS_HIGH_BANK, fileAddr}; // RL4
        end
    end
endmodule // file_addr_resolve
`default_nettype wire

// >>> logic/byte_alu_branch_bitclear_decode.sv
// Decode and execute for add-with-carry, AND, branch-on-carry and bit-clear
//
// Contract
// RL1: Add-with-carry sums accumulator, file, carry; flags
// RL2: Destination bit zero to accumulator, one to file
// RL3: Default destination for AND-file is file
// RL4: Bank bit zero access bank, one bank pointer
// RL5: Extended mode, access, address<=95: indexed offset
// RL6: AND immediate into accumulator, only N, Z
// RL7: AND file routed by destination, only N, Z
// RL8: Branch only on carry one, flags unchanged
// RL9: Signed offset doubled and added on branch
// RL10: Target is branch address plus two plus twice
// RL11: Taken branch two cycles, untaken one cycle
// RL12: Bit-clear clears indexed bit, flags unchanged
`default_nettype none
module byte_alu_branch_bitclear_decode (
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    input  wire logic                                    instrValid,
    input  wire logic        [15:0]                      instrWord,
    input  wire logic        [alu_decode_pkg::PC_W-1:0]  pcIncremented,
    input  wire logic        [7:0]                       fileReadData,
    input  wire logic        [3:0]                       bankPointer,
    input  wire logic                                    extendedEn,
    input  wire logic        [7:0]                       indexBase,
    output logic             [alu_decode_pkg::ADDR_W-1:0] fileReadAddr,
    output alu_decode_pkg::mem_write_t                   fileWrite,
    output logic             [alu_decode_pkg::PC_W-1:0]  pcLoadValue,
    output logic                                         pcLoad,
    output logic                                         stall,
    output logic             [7:0]                       accum,
    output alu_decode_pkg::flags_t                       flags
);
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_NOP  = 2'b10
    } state_t;

    state_t state_q;
    state_t state_d;

    logic       isAddc;
    logic       isAndFile;
    logic       isAndImm;
    logic       isBrCarry;
    logic       isBitClr;
    logic       destFile;
    logic       execOk;
    logic       branchTaken;

    logic [5:0] opcode6;
    logic [7:0] opcode8;
    logic [3:0] opcode4;
    logic [7:0] fileAddr;
    logic [7:0] literal;
    logic [2:0] bitIndex;
    logic       bankSel;
    logic       carryIn;

    logic [7:0] result;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] clearMask;
    alu_decode_pkg::flags_t flags_d;
    logic [alu_decode_pkg::PC_W-1:0] offset2;
    logic [alu_decode_pkg::PC_W-1:0] branchTarget;

    logic       flagsWrEn;
    logic       accumWrEn;
    logic       fileWrEn;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // Offset counts words, so it is sign extended and doubled to bytes
    function automatic logic [alu_decode_pkg::PC_W-1:0] word_offset(input logic [7:0] n);
        return {{(alu_decode_pkg::PC_W-9){n[7]}}, n, 1'b0};
    endfunction

    // Fields are cut once so every decoder reads the same slice
    assign opcode6  = instrWord[15:10];
    assign opcode8  = instrWord[15:8];
    assign opcode4  = instrWord[15:12];
    assign fileAddr = instrWord[7:0];
    assign literal  = instrWord[7:0];
    assign bitIndex = instrWord[11:9];
    assign bankSel  = instrWord[alu_decode_pkg::BANK_BIT];
    assign carryIn  = flags.carry;

    assign execOk    = instrValid && (state_q == ST_EXEC);
    assign isAddc    = opcode6 == alu_decode_pkg::OPC_ADDC_FILE;
    assign isAndFile = opcode6 == alu_decode_pkg::OPC_AND_FILE;
    assign isAndImm  = opcode8 == alu_decode_pkg::OPC_AND_IMM;
    assign isBrCarry = opcode8 == alu_decode_pkg::OPC_BR_CARRY;
    assign isBitClr  = opcode4 == alu_decode_pkg::OPC_BIT_CLR;
    // Assembler fills d=1 when omitted, so hardware just follows the bit
    assign destFile  = instrWord[alu_decode_pkg::DEST_BIT]; // RL2 RL3

    file_addr_resolve addrResolve (
        .fileAddr    (fileAddr),
        .bankSel     (bankSel),
        .bankPointer (bankPointer),
        .extendedEn  (extendedEn),
        .indexBase   (indexBase),
        .memAddr     (fileReadAddr)
    );

    assign sum9 = {1'b0, accum} + {1'b0, fileReadData} + {8'h00, carryIn}; // RL1
    assign sum5 = {1'b0, accum[3:0]} + {1'b0, fileReadData[3:0]} + {4'h0, carryIn};
    assign clearMask = ~(8'h01 << bitIndex); // RL12
    assign branchTaken = execOk && isBrCarry && carryIn; // RL8
    // Pc already points past this word, so no extra step is added here
    assign offset2 = word_offset(literal); // RL9
    assign branchTarget = pcIncremented + offset2; // RL10

    always_comb begin
        result = 8'h00;
        if (isAddc) begin
            result = sum9[7:0]; // RL1
        end else if (isAndFile) begin
            result = accum & fileReadData; // RL7
        end else if (isAndImm) begin
            result = accum & literal; // RL6
        end else if (isBitClr) begin
            result = fileReadData & clearMask; // RL12
        end
    end

    // Carry, half-carry and wrap move only on the add; AND keeps them
    always_comb begin
        flags_d = flags;
        if (isAddc) begin
            flags_d.carry      = sum9[8]; // RL1
            flags_d.halfCarry  = sum5[4];
            flags_d.signedWrap = (accum[7] == fileReadData[7]) && (sum9[7] != accum[7]);
            flags_d.negative   = result[7];
            flags_d.zero       = is_zero(result);
        end else if (isAndFile || isAndImm) begin
            flags_d.negative   = result[7]; // RL6 RL7
            flags_d.zero       = is_zero(result);
        end
    end

    // Branch and bit-clear are left out, so their flags never move
    assign flagsWrEn = execOk && (isAddc || isAndFile || isAndImm); // RL8 RL12
    assign accumWrEn = execOk && (isAndImm || ((isAddc || isAndFile) && !destFile)); // RL2 RL6
    assign fileWrEn  = execOk && (isBitClr || ((isAddc || isAndFile) && destFile)); // RL2 RL3 RL12

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (branchTaken) begin
                    state_d = ST_NOP; // RL11
                end
            end
            ST_NOP: begin
                state_d = ST_EXEC; // RL11
            end
            default: state_d = ST_EXEC;
        endcase
    end

    // Fetched word during the flush cycle is discarded
    assign stall = (state_q == ST_NOP); // RL11

    // Reset lands in execute so the first word after release is taken
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
        end else if (flagsWrEn) begin
            flags <= flags_d; // RL8 RL12
        end
    end

    // Accumulator holds through the stall cycle and refused words
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accum <= 8'h00;
        end else if (accumWrEn) begin
            accum <= result; // RL2 RL6
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fileWrite <= '0;
        end else begin
            fileWrite.wrEn <= fileWrEn; // RL2 RL3 RL12
            fileWrite.addr <= fileReadAddr;
            fileWrite.data <= result;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pcLoad <= 1'b0;
        end else begin
            pcLoad <= branchTaken; // RL11
        end
    end

    // Target stands after the pulse; only pcLoad qualifies it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pcLoadValue <= '0;
        end else if (branchTaken) begin
            pcLoadValue <= branchTarget; // RL10
        end
    end
endmodule // byte_alu_branch_bitclear_decode
`default_nettype wire

// >>> verif/byte_alu_branch_bitclear_decode_monitor.sv
// Port checker for the decode, branch and bit-clear block
`default_nettype none
module byte_alu_branch_bitclear_decode_monitor (
    input wire logic                              ref_clk,
    input wire logic                              rst_b,
    input wire logic                              instrValid,
    input wire logic [15:0]                       instrWord,
    input wire logic [alu_decode_pkg::PC_W-1:0]   pcIncremented,
    input wire logic [7:0]                        fileReadData,
    input wire logic [3:0]                        bankPointer,
    input wire logic                              extendedEn,
    input wire logic [7:0]                        indexBase,
    input wire logic [alu_decode_pkg::ADDR_W-1:0] fileReadAddr,
    input wire alu_decode_pkg::mem_write_t        fileWrite,
    input wire logic [alu_decode_pkg::PC_W-1:0]   pcLoadValue,
    input wire logic                              pcLoad,
    input wire logic                              stall,
    input wire logic [7:0]                        accum,
    input wire alu_decode_pkg::flags_t            flags
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Words offered during the stall cycle are not executed
    wire logic take = instrValid && !stall;
    wire logic br   = take && instrWord[15:8] == 8'hE2;
    wire logic adf  = take && instrWord[15:10] == 6'h08;
    wire logic anf  = take && instrWord[15:10] == 6'h05;

    a_branch_taken: assert property (br && flags.carry |=> pcLoad && stall) else $error("taken branch no load");
    a_branch_target: assert property (br && flags.carry |=> pcLoadValue == $past(pcIncremented) +
        {{12{$past(instrWord[7])}}, $past(instrWord[7:0]), 1'b0}) else $error("branch target wrong");
    a_branch_untaken: assert property (br && !flags.carry |=> !pcLoad && !stall) else $error("untaken branch moved");
    a_branch_flags: assert property (br |=> flags == $past(flags)) else $error("branch changed flags");
    a_stall_single: assert property (stall |=> !stall) else $error("stall too long");
    a_and_imm: assert property (take && instrWord[15:8] == 8'h0B |=>
        accum == ($past(accum) & $past(instrWord[7:0])) && flags.zero == (accum == 8'h00)
        && flags.carry == $past(flags.carry)) else $error("and immediate wrong");
    a_accum_dest: assert property ((adf || anf) && !instrWord[9] |=> !fileWrite.wrEn) else $error("file written");
    a_add_file: assert property (adf && instrWord[9] |=> fileWrite.wrEn &&
        fileWrite.data == 8'($past(accum) + $past(fileReadData) + $past(flags.carry))) else $error("add carry wrong");
    a_bit_clear: assert property (take && instrWord[15:12] == 4'h9 |=> fileWrite.wrEn &&
        flags == $past(flags) && fileWrite.data == ($past(fileReadData) & ~(8'h01 << $past(instrWord[11:9]))))
        else $error("bit clear wrong");
    a_bank_pointer: assert property ((adf || anf) && instrWord[8] |->
        fileReadAddr == {bankPointer, instrWord[7:0]}) else $error("bank address wrong");
    a_indexed_mode: assert property ((adf || anf) && !instrWord[8] && extendedEn && instrWord[7:0] <= 8'h5F |->
        fileReadAddr == {4'h0, 8'(indexBase + instrWord[7:0])}) else $error("indexed address wrong");
    cover property (br && flags.carry);
    cover property (br && !flags.carry);
    cover property (take && instrWord[15:12] == 4'h9);
endmodule // byte_alu_branch_bitclear_decode_monitor
bind byte_alu_branch_bitclear_decode byte_alu_branch_bitclear_decode_monitor i_mon (.ref_clk, .rst_b, .instrValid,
    .instrWord, .pcIncremented, .fileReadData, .bankPointer, .extendedEn, .indexBase, .fileReadAddr, .fileWrite,
    .pcLoadValue, .pcLoad, .stall, .accum, .flags);
`default_nettype wire

// >>> verif/byte_alu_branch_bitclear_decode_test.sv
// Directed bench for the decode, branch and bit-clear block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module byte_alu_branch_bitclear_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic                              ref_clk = 1'b0;
    logic                              rst_b = 1'b0;
    logic                              instrValid = 1'b0;
    logic [15:0]                       instrWord = 16'h0000;
    logic [alu_decode_pkg::PC_W-1:0]   pcIncremented = 21'h000200;
    logic [7:0]                        fileReadData = 8'h00;
    logic [3:0]                        bankPointer = 4'h3;
    logic                              extendedEn = 1'b1;
    logic [7:0]                        indexBase = 8'hF0;
    logic [alu_decode_pkg::ADDR_W-1:0] fileReadAddr, rdAddr;
    alu_decode_pkg::mem_write_t        fileWrite;
    logic [alu_decode_pkg::PC_W-1:0]   pcLoadValue;
    logic                              pcLoad, stall;
    logic [7:0]                        accum;
    alu_decode_pkg::flags_t            flags;
    logic [7:0]                        offs [3] = '{8'hFB, 8'h7F, 8'h80};
    logic [20:0]                       tgt [3] = '{21'h0001F6, 21'h0002FE, 21'h000100};
    int                                n_fail = 0, total_checks = 0, cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    byte_alu_branch_bitclear_decode i_dut (.ref_clk, .rst_b, .instrValid, .instrWord, .pcIncremented, .fileReadData,
        .bankPointer, .extendedEn, .indexBase, .fileReadAddr, .fileWrite, .pcLoadValue, .pcLoad, .stall, .accum, .flags);

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Whole run is under 60 cycles, so this only trips on a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 500) begin
            n_fail++;
            report_and_stop;
        end
    end

    // Address is combinational, so it is caught while the word is offered
    task go(input logic [15:0] w, input logic [7:0] f);
        @(posedge ref_clk);
        instrValid <= 1'b1;
        instrWord <= w;
        fileReadData <= f;
        #1 rdAddr = fileReadAddr;
    endtask

    task idle;
        @(posedge ref_clk);
        instrValid <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1 `CHK({accum, flags, pcLoad, stall}, 15'h0000)
        go(16'h2110, 8'hC7); `CHK(rdAddr, 12'h310)
        idle; `CHK({accum, flags, fileWrite.wrEn}, {8'hC7, 5'b10000, 1'b0})
        go(16'h2220, 8'h39); `CHK(rdAddr, 12'h010)
        idle; `CHK({fileWrite, accum, flags}, {1'b1, 12'h010, 8'h00, 8'hC7, 5'b00111})
        $display("add with carry done");
        go(16'h0B5F, 8'h00); idle; `CHK({accum, flags}, {8'h47, 5'b00011})
        go(16'h1505, 8'h80); idle; `CHK({accum, flags, fileWrite.wrEn}, {8'h00, 5'b00111, 1'b0})
        go(16'h1705, 8'hFF); idle; `CHK(fileWrite, {1'b1, 12'h305, 8'h00})
        $display("and done");
        go(16'h9F22, 8'hC7); idle; `CHK({fileWrite, flags}, {1'b1, 12'h322, 8'h47, 5'b00111})
        $display("bit clear done");
        // Second word lands in the stall cycle and must be dropped
        for (int i = 0; i < 3; i++) begin
            go(16'hE200 | offs[i], 8'h00);
            go(16'h2110, 8'h55); `CHK({pcLoad, stall, pcLoadValue}, {2'b11, tgt[i]})
            idle; `CHK({pcLoad, stall, accum, flags}, {2'b00, 8'h00, 5'b00111})
        end
        go(16'h2010, 8'h00); idle; `CHK({accum, flags}, {8'h01, 5'b00000})
        go(16'hE205, 8'h00); idle; `CHK({pcLoad, stall, flags}, {2'b00, 5'b00000})
        $display("branch done");
        // Same-sign operands with a sign flip must raise the wrap flag
        go(16'h2110, 8'h7F); `CHK(rdAddr, 12'h310)
        idle; `CHK({accum, flags}, {8'h80, 5'b11010})
        go(16'h20A0, 8'h00); `CHK(rdAddr, 12'hFA0)
        idle; `CHK({accum, flags}, {8'h80, 5'b10000})
        @(posedge ref_clk) extendedEn <= 1'b0;
        go(16'h2010, 8'h80); `CHK(rdAddr, 12'h010)
        idle; `CHK({accum, flags}, {8'h00, 5'b01101})
        $display("wrap and access bank done");
        report_and_stop;
    end
endmodule // byte_alu_branch_bitclear_decode_test
`default_nettype wire
